// ===== rtl/amll_top.sv
// Purpose: alarm output masks and local critical limit
// Assumes: command port and event inputs come from logic on MCLK
// Notes: alarm outputs are active low and registered
`timescale 1ns/100ps
`include "amll_cfg.svh"

module amll_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // command-byte register port
  input wire amll_pkg::amll_byte_t CMD_ADDR,
  input wire logic WR_STB,
  input wire amll_pkg::amll_byte_t WR_DATA,
  input wire logic RD_STB,
  output amll_pkg::amll_byte_t RD_DATA,
  output logic RD_ACK,
  // measurement and shared settings
  input wire amll_pkg::amll_temp_t LOCAL_TEMP,
  input wire amll_pkg::amll_hyst_t HYST_DEG,
  // remote channel events, bit 3 is remote 4
  input wire amll_pkg::amll_remote_t REMOTE_EVENTS_1,
  input wire amll_pkg::amll_remote_t REMOTE_EVENTS_2,
  input wire amll_pkg::amll_remote_t REMOTE_EVENTS_3,
  // local event status
  output logic LOCAL_EVENT,
  // alarm pins
  output logic ALARM_OUT_1_N,
  output logic ALARM_OUT_2_N,
  output logic ALARM_OUT_3_N
);
  import amll_pkg::*;

  amll_chan_t mask_q [`AMLL_NUM_ALARM];
  amll_chan_t status_c [`AMLL_NUM_ALARM];
  logic [`AMLL_NUM_ALARM-1:0] alarm_n_q;
  amll_remote_t remote_c [`AMLL_NUM_ALARM];
  amll_limit_t limit_q;
  amll_byte_t rd_data_q;
  amll_byte_t rd_data_d;
  logic rd_ack_q;

  amll_cmp_if cif ();

  // ==========================================
  // local comparator
  assign cif.temp = LOCAL_TEMP;
  assign cif.limit = limit_q; // [R8]
  assign cif.hyst = HYST_DEG; // [R13]

  amll_local_cmp u_cmp (
    .MCLK (MCLK),
    .RESETN (RESETN),
    .cif (cif.cmp)
  );

  assign LOCAL_EVENT = cif.status;

  // ==========================================
  // local limit register
  // bit 7 is never stored, so no limit above 127 can exist
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      limit_q <= `AMLL_RST_LIMIT; // [R8]
    end else if (WR_STB && CMD_ADDR == `AMLL_CMD_LIMIT) begin
      limit_q <= WR_DATA[`AMLL_LIMIT_W-1:0]; // [R9] [R10] [R14]
    end
  end

  // ==========================================
  // masks and alarms, one slice per alarm pin
  assign remote_c[0] = REMOTE_EVENTS_1;
  assign remote_c[1] = REMOTE_EVENTS_2;
  assign remote_c[2] = REMOTE_EVENTS_3;

  genvar g;
  generate
    for (g = 0; g < `AMLL_NUM_ALARM; g++) begin : g_alarm
      localparam amll_chan_t RST_V = (g == 0) ? `AMLL_RST_MASK1 :
                                     (g == 1) ? `AMLL_RST_MASK2 : `AMLL_RST_MASK3;
      localparam amll_byte_t CMD_V = (g == 0) ? `AMLL_CMD_MASK1 :
                                     (g == 1) ? `AMLL_CMD_MASK2 : `AMLL_CMD_MASK3;

      // local event in bit 0, remotes 1..4 in bits 1..4
      assign status_c[g] = {remote_c[g], cif.status}; // [R4]

      always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          mask_q[g] <= RST_V; // [R1] [R2] [R3]
        end else if (WR_STB && CMD_ADDR == CMD_V) begin
          mask_q[g] <= WR_DATA[`AMLL_MASK_W-1:0]; // [R7] [R14]
        end
      end

      // set mask bit blocks, clear mask bit passes
      always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          alarm_n_q[g] <= 1'b1;
        end else begin
          alarm_n_q[g] <= ~|(status_c[g] & ~mask_q[g]); // [R5] [R6] [R11]
        end
      end
    end
  endgenerate

  assign ALARM_OUT_1_N = alarm_n_q[0];
  assign ALARM_OUT_2_N = alarm_n_q[1];
  assign ALARM_OUT_3_N = alarm_n_q[2];

  // ==========================================
  // read path
  // unmapped commands read zero so the engine always gets a byte
  always_comb begin
    case (CMD_ADDR)
      `AMLL_CMD_MASK1: rd_data_d = {3'h0, mask_q[0]}; // [R7]
      `AMLL_CMD_MASK2: rd_data_d = {3'h0, mask_q[1]}; // [R7]
      `AMLL_CMD_MASK3: rd_data_d = {3'h0, mask_q[2]}; // [R7]
      `AMLL_CMD_LIMIT: rd_data_d = {1'b0, limit_q}; // [R10]
      default: rd_data_d = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_data_q <= 8'h00;
    end else if (RD_STB) begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= RD_STB;
    end
  end

  assign RD_DATA = rd_data_q;
  assign RD_ACK = rd_ack_q;

  // ==========================================
  // checks
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_mask1_wr;
    (WR_STB && CMD_ADDR == 8'h0c) |=> (mask_q[0] == $past(WR_DATA[4:0]));
  endproperty
  a_mask1_wr: assert property (p_mask1_wr) else $error("mask one write lost"); // [R1]

  property p_mask2_wr;
    (WR_STB && CMD_ADDR == 8'h0d) |=> (mask_q[1] == $past(WR_DATA[4:0]));
  endproperty
  a_mask2_wr: assert property (p_mask2_wr) else $error("mask two write lost"); // [R2]

  property p_mask3_wr;
    (WR_STB && CMD_ADDR == 8'h0e) |=> (mask_q[2] == $past(WR_DATA[4:0]));
  endproperty
  a_mask3_wr: assert property (p_mask3_wr) else $error("mask three write lost"); // [R3]

  property p_mask_rd;
    (RD_STB && CMD_ADDR >= 8'h0c && CMD_ADDR <= 8'h0e && !WR_STB)
      |=> (RD_DATA[7:5] == 3'h0) && RD_ACK;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask high bits not zero"); // [R7]

  property p_limit_rd;
    (RD_STB && CMD_ADDR == 8'h40) |=> (RD_DATA == {1'b0, $past(limit_q)});
  endproperty
  a_limit_rd: assert property (p_limit_rd) else $error("limit readback wrong"); // [R10]

  property p_alarm_eq;
    1'b1 |=> (ALARM_OUT_1_N == !$past(|({REMOTE_EVENTS_1, LOCAL_EVENT} & ~mask_q[0])));
  endproperty
  a_alarm_eq: assert property (p_alarm_eq) else $error("alarm one mismatch"); // [R11]

  property p_all_blocked;
    (mask_q[1] == 5'h1f) |=> ALARM_OUT_2_N;
  endproperty
  a_all_blocked: assert property (p_all_blocked) else $error("blocked event leaked"); // [R5]

  property p_pass;
    (remote_c[2][3] && !mask_q[2][4]) |=> !ALARM_OUT_3_N;
  endproperty
  a_pass: assert property (p_pass) else $error("remote 4 event did not pass"); // [R6]

  property p_limit_wr;
    (WR_STB && CMD_ADDR == 8'h40)
      |=> (limit_q == $past(WR_DATA[6:0]));
  endproperty
  a_limit_wr: assert property (p_limit_wr) else $error("limit write lost"); // [R9]

  property p_limit_keep;
    !(WR_STB && CMD_ADDR == 8'h40)
      |=> $stable(limit_q);
  endproperty
  a_limit_keep: assert property (p_limit_keep) else $error("limit moved without write"); // [R8]

  property p_unmapped_rd;
    (RD_STB && CMD_ADDR != 8'h0c && CMD_ADDR != 8'h0d
      && CMD_ADDR != 8'h0e && CMD_ADDR != 8'h40)
      |=> (RD_DATA == 8'h00);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  property p_ack_pulse;
    RD_STB |=> RD_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("read not acknowledged");

  property p_ack_idle;
    !RD_STB |=> !RD_ACK;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("acknowledge without read");

  property p_rd_hold;
    !RD_STB |=> $stable(RD_DATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

  // ==========================================
  // local event seen from the pins
  // thresholds restated from the rules, not taken from the comparator
  property p_evt_rise;
    ($signed(LOCAL_TEMP) >= $signed({1'b0, limit_q}))
      |=> LOCAL_EVENT;
  endproperty
  a_evt_rise: assert property (p_evt_rise) else $error("local event missed"); // [R12]

  property p_evt_quiet;
    (!LOCAL_EVENT && $signed(LOCAL_TEMP) < $signed({1'b0, limit_q}))
      |=> !LOCAL_EVENT;
  endproperty
  a_evt_quiet: assert property (p_evt_quiet) else $error("local event set below limit"); // [R12]

  property p_evt_fall;
    (HYST_DEG <= 6'h20 && 10'(LOCAL_TEMP) + $signed({4'h0, HYST_DEG})
      < $signed({3'h0, limit_q})) |=> !LOCAL_EVENT;
  endproperty
  a_evt_fall: assert property (p_evt_fall) else $error("local event stuck"); // [R12]

  property p_evt_hold;
    (HYST_DEG <= 6'h20 && LOCAL_EVENT && 10'(LOCAL_TEMP) + $signed({4'h0, HYST_DEG})
      >= $signed({3'h0, limit_q})) |=> LOCAL_EVENT;
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("local event dropped in band"); // [R13]

  property p_evt_clip;
    (HYST_DEG > 6'h20 && 10'(LOCAL_TEMP) + 10'sh020
      < $signed({3'h0, limit_q})) |=> !LOCAL_EVENT;
  endproperty
  a_evt_clip: assert property (p_evt_clip) else $error("clipped hysteresis not applied"); // [R13]

  property p_evt_band;
    (HYST_DEG > 6'h20 && LOCAL_EVENT && 10'(LOCAL_TEMP) + 10'sh020
      >= $signed({3'h0, limit_q})) |=> LOCAL_EVENT;
  endproperty
  a_evt_band: assert property (p_evt_band) else $error("clipped band not held"); // [R13]

  // ==========================================
  // per-pin checks
  for (genvar k = 0; k < `AMLL_NUM_ALARM; k++) begin : g_chk
    localparam amll_byte_t CMD_K = 8'(8'h0c + k);

    property p_mask_keep;
      @(posedge MCLK) disable iff (!RESETN)
        !(WR_STB && CMD_ADDR == CMD_K) |=> $stable(mask_q[k]);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask moved without write"); // [R1]

    property p_mask_rd_val;
      @(posedge MCLK) disable iff (!RESETN)
        (RD_STB && CMD_ADDR == CMD_K) |=> (RD_DATA == {3'h0, $past(mask_q[k])});
    endproperty
    a_mask_rd_val: assert property (p_mask_rd_val) else $error("mask readback wrong"); // [R7]

    property p_remote_pass;
      @(posedge MCLK) disable iff (!RESETN)
        (|(remote_c[k] & ~mask_q[k][4:1])) |=> !alarm_n_q[k];
    endproperty
    a_remote_pass: assert property (p_remote_pass) else $error("remote event lost"); // [R6]

    property p_local_pass;
      @(posedge MCLK) disable iff (!RESETN)
        (LOCAL_EVENT && !mask_q[k][0]) |=> !alarm_n_q[k];
    endproperty
    a_local_pass: assert property (p_local_pass) else $error("local event lost"); // [R4]

    property p_blocked;
      @(posedge MCLK) disable iff (!RESETN)
        ((remote_c[k] & ~mask_q[k][4:1]) == 4'h0 && !(LOCAL_EVENT && !mask_q[k][0]))
          |=> alarm_n_q[k];
    endproperty
    a_blocked: assert property (p_blocked) else $error("masked event reached pin"); // [R5]
  end

  // ==========================================
  // covers
  c_alarm1: cover property (!ALARM_OUT_1_N);
  c_limit_wr: cover property (WR_STB && CMD_ADDR == 8'h40);
  c_alarm3_clear: cover property (!ALARM_OUT_3_N ##1 ALARM_OUT_3_N);
  c_local_rise: cover property ($rose(LOCAL_EVENT));
  c_mask2_read: cover property (RD_STB && CMD_ADDR == 8'h0d);
endmodule : amll_top

// ===== rtl/amll_cfg.svh
// Purpose: constants of the alarm mask and local limit block
// Assumes: command-byte register port driven by the serial engine on MCLK
// Notes: offsets are command bytes, not bus addresses
// Operation
// R1 - first alarm mask at command 0x0c, resets to 0x19, gates alarm one.
// R2 - second alarm mask at command 0x0d, resets to 0x00, gates alarm two.
// R3 - third alarm mask at command 0x0e, resets to 0x07, gates alarm three.
// R4 - mask bits 4..1 gate remote channels 4..1, bit 0 gates local channel.
// R5 - a mask bit at one blocks that channel event from the alarm.
// R6 - a mask bit at zero lets that channel event reach the alarm.
// R7 - mask bits 7..5 are read-only and always read zero.
// R8 - local critical limit at command 0x40, resets to 0x55, sets local event.
// R9 - local limit is unsigned 0..127 degrees in bits 6..0.
// R10 - local limit bit 7 is read-only and reads zero.
// R11 - alarm active while any unmasked status bit set, inactive when all clear.
// R12 - local status sets at reading >= limit, clears below limit minus hysteresis.
// R13 - one shared 0..32 degree hysteresis lowers the falling threshold.
// R14 - writes to read-only bits are ignored; those bits stay zero.
`ifndef AMLL_CFG_SVH
`define AMLL_CFG_SVH

// ==========================================
// command bytes
`define AMLL_CMD_MASK1 8'h0c
`define AMLL_CMD_MASK2 8'h0d
`define AMLL_CMD_MASK3 8'h0e
`define AMLL_CMD_LIMIT 8'h40

// ==========================================
// reset values
`define AMLL_RST_MASK1 5'h19
`define AMLL_RST_MASK2 5'h00
`define AMLL_RST_MASK3 5'h07
`define AMLL_RST_LIMIT 7'h55

// ==========================================
// field positions and widths
`define AMLL_MASK_W 5
`define AMLL_LIMIT_W 7
`define AMLL_HYST_W 6
`define AMLL_BIT_LOCAL 0
`define AMLL_BIT_REM1 1
`define AMLL_BIT_REM4 4
`define AMLL_NUM_ALARM 3
`define AMLL_HYST_MAX 6'h20

`endif

// ===== rtl/amll_pkg.sv
// Purpose: shared types of the alarm mask and local limit block
// Assumes: nothing beyond the constants header
// Notes: types only, numbers live in amll_cfg.svh
`include "amll_cfg.svh"

package amll_pkg;
  // ==========================================
  // types
  typedef logic [`AMLL_MASK_W-1:0] amll_chan_t;
  typedef logic [`AMLL_MASK_W-2:0] amll_remote_t;
  typedef logic [`AMLL_LIMIT_W-1:0] amll_limit_t;
  typedef logic [`AMLL_HYST_W-1:0] amll_hyst_t;
  typedef logic signed [7:0] amll_temp_t;
  typedef logic [7:0] amll_byte_t;
endpackage : amll_pkg

// ===== rtl/amll_cmp_if.sv
// Purpose: carrier between register side and local comparator
// Assumes: all signals on MCLK
// Notes: status is registered in the comparator
`timescale 1ns/100ps

interface amll_cmp_if;
  import amll_pkg::*;
  amll_temp_t temp;
  amll_limit_t limit;
  amll_hyst_t hyst;
  logic status;
  modport cmp (input temp, input limit, input hyst, output status);
  modport user (output temp, output limit, output hyst, input status);
endinterface : amll_cmp_if

// ===== rtl/amll_local_cmp.sv
// Purpose: local channel over-limit status with shared hysteresis
// Assumes: reading is signed whole degrees, same clock
// Notes: holds state between the two thresholds
`timescale 1ns/100ps
`include "amll_cfg.svh"

module amll_local_cmp (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // comparator carrier
  amll_cmp_if.cmp cif
);
  import amll_pkg::*;

  logic status_q;
  logic signed [9:0] temp_s;
  logic signed [9:0] rise_s;
  logic signed [9:0] fall_s;
  amll_hyst_t hyst_c;

  // ==========================================
  // thresholds
  // hysteresis above 32 is clipped so a bad value cannot hold the alarm forever
  assign hyst_c = (cif.hyst > `AMLL_HYST_MAX) ? `AMLL_HYST_MAX : cif.hyst; // [R13]
  assign temp_s = 10'(cif.temp);
  assign rise_s = 10'(signed'({3'h0, cif.limit})); // [R9]
  assign fall_s = rise_s - 10'(signed'({4'h0, hyst_c})); // [R13]

  // ==========================================
  // status
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      status_q <= 1'b0;
    end else if (temp_s >= rise_s) begin
      status_q <= 1'b1; // [R12]
    end else if (temp_s < fall_s) begin
      status_q <= 1'b0; // [R12]
    end
  end

  assign cif.status = status_q;

  // ==========================================
  // checks
  property p_local_set;
    @(posedge MCLK) disable iff (!RESETN)
      (temp_s >= rise_s) |=> status_q;
  endproperty
  a_local_set: assert property (p_local_set) else $error("local status not set"); // [R12]

  property p_local_hold;
    @(posedge MCLK) disable iff (!RESETN)
      (temp_s < rise_s && temp_s >= fall_s) |=> (status_q == $past(status_q));
  endproperty
  a_local_hold: assert property (p_local_hold) else $error("status moved in band"); // [R13]

  property p_local_clr;
    @(posedge MCLK) disable iff (!RESETN)
      (temp_s < fall_s) |=> !status_q;
  endproperty
  a_local_clr: assert property (p_local_clr) else $error("local status not cleared"); // [R12]
endmodule : amll_local_cmp

// ===== test/amll_host.sv
// Purpose: host model on the command-byte port
// Assumes: one request at a time, driven just after MCLK rises
// Notes: idle write data shows the inverse of the last byte
`timescale 1ns/100ps

module amll_host (
  // clock
  input wire logic mclk,
  // requests
  output amll_pkg::amll_byte_t cmd_addr,
  output logic wr_stb,
  output amll_pkg::amll_byte_t wr_data,
  output logic rd_stb,
  // answers
  input wire amll_pkg::amll_byte_t rd_data,
  input wire logic rd_ack
);
  import amll_pkg::*;
  // ====
  // idle
  initial begin
    cmd_addr = 8'h00;
    wr_stb = 1'h0;
    wr_data = 8'h00;
    rd_stb = 1'h0;
  end
  // ====
  // transfers
  task automatic wr(input amll_byte_t a, input amll_byte_t d);
    @(posedge mclk);
    cmd_addr <= a;
    wr_data <= d;
    wr_stb <= 1'h1;
    @(posedge mclk);
    wr_stb <= 1'h0;
    wr_data <= ~d;
  endtask : wr
  // bounded wait, a dead port cannot hang the run
  task automatic rd(input amll_byte_t a, output amll_byte_t d, output logic to);
    to = 1'h1;
    d = 8'h00;
    @(posedge mclk);
    cmd_addr <= a;
    rd_stb <= 1'h1;
    @(posedge mclk);
    rd_stb <= 1'h0;
    for (int i = 0; i < 4 && to; i++) begin
      @(posedge mclk);
      if (rd_ack === 1'h1) begin
        d = rd_data;
        to = 1'h0;
      end
    end
  endtask : rd
endmodule : amll_host

// ===== test/amll_top_bench.sv
// Purpose: self-checking bench of the alarm mask block
// Assumes: 250 MHz clock, reset low for 8 cycles
// Notes: three edges of settling cover the two-cycle local path
`timescale 1ns/100ps

module amll_top_bench;
  import amll_pkg::*;
  logic mclk = 1'h0;
  logic resetn;
  amll_byte_t cmd_addr, wr_data, rd_data;
  logic wr_stb, rd_stb, rd_ack;
  wire local_event;
  wire [2:0] alarm_n;
  amll_temp_t local_temp;
  amll_hyst_t hyst_deg;
  amll_remote_t rem [3];
  int err_count;
  int tests_run;
  amll_byte_t cmds [4] = '{8'h0c, 8'h0d, 8'h0e, 8'h40};
  amll_byte_t rstv [4] = '{8'h19, 8'h00, 8'h07, 8'h55};
  amll_temp_t tv [7] = '{8'h3f, 8'h40, 8'h3d, 8'h3b, 8'h40, 8'h21, 8'h1f};
  amll_hyst_t hv [7] = '{6'h04, 6'h04, 6'h04, 6'h04, 6'h28, 6'h28, 6'h28};
  logic [0:6] ev = 7'h36;
  always #2 mclk = ~mclk;
  amll_top amll_top_inst (.MCLK(mclk), .RESETN(resetn), .CMD_ADDR(cmd_addr),
    .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .RD_ACK(rd_ack), .LOCAL_TEMP(local_temp), .HYST_DEG(hyst_deg),
    .REMOTE_EVENTS_1(rem[0]), .REMOTE_EVENTS_2(rem[1]), .REMOTE_EVENTS_3(rem[2]),
    .LOCAL_EVENT(local_event), .ALARM_OUT_1_N(alarm_n[0]),
    .ALARM_OUT_2_N(alarm_n[1]), .ALARM_OUT_3_N(alarm_n[2]));
  amll_host amll_host_inst (.mclk(mclk), .cmd_addr(cmd_addr), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_ack(rd_ack));
  // ====
  // helpers
  task automatic chk(input string what, input amll_byte_t exp, input amll_byte_t got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic rdchk(input amll_byte_t a, input amll_byte_t exp);
    amll_byte_t d;
    logic to;
    amll_host_inst.rd(a, d, to);
    if (to) begin
      err_count++;
      $display("mismatch read ack expected 1 seen 0");
      close_out;
    end else begin
      chk($sformatf("read of %h", a), exp, d);
    end
  endtask : rdchk
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  // ====
  // sequence
  initial begin
    resetn = 1'h0;
    local_temp = 8'h00;
    hyst_deg = 6'h04;
    rem = '{default: 4'h0};
    err_count = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'h1;
    foreach (cmds[i]) rdchk(cmds[i], rstv[i]);
    chk("alarms idle", 8'h07, alarm_n);
    $display("test reset values done");
    amll_host_inst.wr(8'h0f, 8'hff);
    rdchk(8'h0f, 8'h00);
    foreach (cmds[i]) begin
      amll_host_inst.wr(cmds[i], 8'hff);
      rdchk(cmds[i], i == 3 ? 8'h7f : 8'h1f);
      amll_host_inst.wr(cmds[i], i == 3 ? 8'h80 : 8'he0);
      rdchk(cmds[i], 8'h00);
    end
    amll_host_inst.wr(8'h40, 8'h40);
    $display("test read-only bits done");
    for (int n = 0; n < 3; n++) begin
      for (int b = 0; b < 4; b++) begin
        @(posedge mclk);
        rem[n] <= amll_remote_t'(4'h1 << b);
        amll_host_inst.wr(amll_byte_t'(8'h0c + n), amll_byte_t'(8'h02 << b));
        settle;
        chk("alarm blocked", 8'h01, alarm_n[n]);
        amll_host_inst.wr(amll_byte_t'(8'h0c + n), 8'h1f & ~amll_byte_t'(8'h02 << b));
        settle;
        chk("alarm passed", 8'h00, alarm_n[n]);
        @(posedge mclk);
        rem[n] <= 4'h0;
        settle;
        chk("alarm released", 8'h01, alarm_n[n]);
      end
      amll_host_inst.wr(amll_byte_t'(8'h0c + n), 8'h00);
    end
    $display("test remote masking done");
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      local_temp <= tv[i];
      hyst_deg <= hv[i];
      settle;
      chk("local event", ev[i], local_event);
      chk("alarms local", {5'h00, {3{~ev[i]}}}, alarm_n);
    end
    @(posedge mclk);
    local_temp <= 8'h40;
    for (int n = 0; n < 3; n++) amll_host_inst.wr(amll_byte_t'(8'h0c + n), 8'h01);
    settle;
    chk("local blocked", 8'h07, alarm_n);
    $display("test local limit done");
    @(posedge mclk);
    resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    foreach (cmds[i]) rdchk(cmds[i], rstv[i]);
    chk("alarms after reset", 8'h07, alarm_n);
    chk("local event after reset", 8'h00, local_event);
    $display("test mid-run reset done");
    close_out;
  end
endmodule : amll_top_bench
